//--- include/mcb_pkg.sv
// Package for the machine control bits block: field positions, reset
// values, trap vectors, the move and instruction enums and the carrier structs.
// Assumes a single 20 MHz core clock and an active-low asynchronous reset.
package mcb_pkg;

    // ========================================================================
    // Field positions of the main control word.
    // ========================================================================
    localparam int MCB_BIT_PROT      = 0;   // Protection enable.
    localparam int MCB_BIT_MONITOR   = 1;   // Coprocessor monitor.
    localparam int MCB_BIT_EMULATE   = 2;   // Coprocessor emulate.
    localparam int MCB_BIT_TASKSW    = 3;   // Task switched.
    localparam int MCB_BIT_NUMEXC    = 5;   // Numerics exception.
    localparam int MCB_BIT_WRPROT    = 16;  // Write protect.
    localparam int MCB_BIT_PAGING    = 31;  // Paging enable.

    // Bits that hold state; everything else reads zero and drops writes.
    localparam logic [31:0] MCB_WRITABLE_MASK = 32'hE005_002F;
    // Bits an alias load of the low half touches.
    localparam logic [31:0] MCB_LOW_HALF_MASK = 32'h0000_FFFF;
    // Reset value of the main control word (upper cache bit is out of scope).
    localparam logic [31:0] MCB_RESET_VALUE   = 32'h0000_0000;
    // The reserved second control word always reads this value.
    localparam logic [31:0] MCB_RSVD_VALUE    = 32'h0000_0000;
    // Trap vector for device-not-available.
    localparam logic [7:0]  MCB_VEC_DNA       = 8'h07;
    // Trap vector and error code of the general-protection fault.
    localparam logic [7:0]  MCB_VEC_GP        = 8'h0D;
    localparam logic [15:0] MCB_GP_ERRCODE    = 16'h0000;
    // Lowest privilege level still allowed to write read-only pages.
    localparam logic [1:0]  MCB_SUPER_MAX_CPL = 2'h2;

    // Register selection on the move port.
    typedef enum logic [1:0] {
        MCB_SEL_MAIN = 2'b00,
        MCB_SEL_RSVD = 2'b01,
        MCB_SEL_LOW  = 2'b10
    } mcb_sel_type;

    // Kind of instruction offered for trap checking.
    typedef enum logic [1:0] {
        MCB_INS_NONE  = 2'b00,
        MCB_INS_FLOAT = 2'b01,
        MCB_INS_WAIT  = 2'b10
    } mcb_ins_type;

    // A register move request from the execution unit.
    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        mcb_sel_type sel;
        logic [31:0] data;
    } mcb_move_type;

    // A page write check request.
    typedef struct packed {
        logic       valid;
        logic       readOnly;
        logic [1:0] cpl;
    } mcb_page_type;

    // A fault report.
    typedef struct packed {
        logic        valid;
        logic [7:0]  vector;
        logic [15:0] errCode;
    } mcb_fault_type;

endpackage : mcb_pkg

//--- design/mcb_trap_decode.sv
// Combinational trap decision for floating-point and wait instructions.
// Assumes its control inputs come straight from the control word flops.
`timescale 1ns/100ps
`default_nettype none
module mcb_trap_decode
    import mcb_pkg::*;
(
    input  wire mcb_ins_type insKind,
    input  wire logic        taskSwitched,
    input  wire logic        monitor,
    output logic             trap
);

    // ========================================================================
    // Decision.
    // ========================================================================
    // Floating-point always traps; the core has no numerics unit, so the
    // emulate and numerics bits do not change the outcome.
    always_comb begin
        case (insKind)
            MCB_INS_FLOAT: trap = 1'b1;
            MCB_INS_WAIT:  trap = monitor & taskSwitched;
            default:       trap = 1'b0;
        endcase
    end

endmodule : mcb_trap_decode
`default_nettype wire

//--- design/mcb_control.sv
// Machine control bits: main control word, reserved second word, trap
// decisions for floating-point and wait, and page write protection.
// Assumes the execution unit offers one request of each kind per cycle.
`timescale 1ns/100ps
`default_nettype none
module mcb_control
    import mcb_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire mcb_move_type moveReq,
    input  wire logic         taskSwitch,
    input  wire mcb_ins_type  insKind,
    input  wire mcb_page_type pageReq,
    output logic [31:0]       readData,
    output logic              readValid,
    output mcb_fault_type     fault,
    output logic              pageFault,
    output logic              protMode,
    output logic              pagingOn,
    output logic              writeProtect,
    output logic              numExcBit
);

    // ========================================================================
    // State.
    // ========================================================================
    // All flops of the block in one struct.
    typedef struct packed {
        logic [31:0]   ctrlWord;   // Main control word, stored bits only.
        logic [31:0]   readData;   // Read answer.
        logic          readValid;  // Read answer marker.
        mcb_fault_type fault;      // Instruction or load fault.
        logic          pageFault;  // Page write fault.
    } mcb_state_type;

    mcb_state_type state_reg;  // Registered state.
    mcb_state_type state_next; // Next state.
    logic          insTrap;    // Decoder verdict.
    logic [31:0]   loadValue;  // Candidate control word for a write.

    // Trap decoder instance.
    mcb_trap_decode u_trap (
        .insKind      (insKind),
        .taskSwitched (state_reg.ctrlWord[MCB_BIT_TASKSW]),
        .monitor      (state_reg.ctrlWord[MCB_BIT_MONITOR]),
        .trap         (insTrap)
    );

    // Merge a written value into the stored word under a mask.
    function automatic logic [31:0] mergeWord(
        input logic [31:0] oldWord,
        input logic [31:0] newWord,
        input logic [31:0] mask
    );
        mergeWord = ((oldWord & ~mask) | (newWord & mask))
                  & MCB_WRITABLE_MASK;
    endfunction : mergeWord

    // ========================================================================
    // Next-state logic.
    // ========================================================================
    // An illegal paging-without-protection load is refused whole, so the
    // word never enters the undefined mode; the load only reports a fault.
    always_comb begin
        state_next           = state_reg;
        state_next.readValid = 1'b0;
        state_next.readData  = 32'h0000_0000;
        state_next.fault     = '0;
        state_next.pageFault = 1'b0;
        loadValue            = state_reg.ctrlWord;
        if (moveReq.wrEn) begin
            case (moveReq.sel)
                MCB_SEL_MAIN: begin
                    loadValue = mergeWord(state_reg.ctrlWord, moveReq.data,
                                          32'hFFFF_FFFF);
                end
                MCB_SEL_LOW: begin
                    loadValue = mergeWord(state_reg.ctrlWord, moveReq.data,
                                          MCB_LOW_HALF_MASK);
                end
                default: begin
                    loadValue = state_reg.ctrlWord;
                end
            endcase
            if (loadValue[MCB_BIT_PAGING] && !loadValue[MCB_BIT_PROT]) begin
                state_next.fault.valid   = 1'b1;
                state_next.fault.vector  = MCB_VEC_GP;
                state_next.fault.errCode = MCB_GP_ERRCODE;
            end else begin
                state_next.ctrlWord = loadValue;
            end
        end
        // A task switch wins over a write clearing the task-switched bit.
        if (taskSwitch) begin
            state_next.ctrlWord[MCB_BIT_TASKSW] = 1'b1;
        end
        // Reads return the stored word; the reserved word reads fixed.
        if (moveReq.rdEn) begin
            state_next.readValid = 1'b1;
            case (moveReq.sel)
                MCB_SEL_MAIN: state_next.readData = state_reg.ctrlWord;
                MCB_SEL_LOW:  state_next.readData = state_reg.ctrlWord
                                                  & MCB_LOW_HALF_MASK;
                default:      state_next.readData = MCB_RSVD_VALUE;
            endcase
        end
        // Device-not-available trap on vector 7. A load fault takes the
        // same slot with priority, as it belongs to an older instruction.
        if (insTrap && !state_next.fault.valid) begin
            state_next.fault.valid   = 1'b1;
            state_next.fault.vector  = MCB_VEC_DNA;
            state_next.fault.errCode = MCB_GP_ERRCODE;
        end
        // Read-only page writes: supervisor levels pass unless protected.
        if (pageReq.valid && pageReq.readOnly) begin
            if (state_reg.ctrlWord[MCB_BIT_WRPROT]) begin
                state_next.pageFault = 1'b1;
            end else begin
                state_next.pageFault = (pageReq.cpl > MCB_SUPER_MAX_CPL);
            end
        end
    end

    // ========================================================================
    // State register.
    // ========================================================================
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg          <= '0;
            state_reg.ctrlWord <= MCB_RESET_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the flops.
    assign readData     = state_reg.readData;
    assign readValid    = state_reg.readValid;
    assign fault        = state_reg.fault;
    assign pageFault    = state_reg.pageFault;
    assign protMode     = state_reg.ctrlWord[MCB_BIT_PROT];
    assign pagingOn     = state_reg.ctrlWord[MCB_BIT_PAGING];
    assign writeProtect = state_reg.ctrlWord[MCB_BIT_WRPROT];
    assign numExcBit    = state_reg.ctrlWord[MCB_BIT_NUMEXC];

    // ========================================================================
    // Assertions.
    // ========================================================================
    // A request taken at one edge is answered at the next, so every
    // property below that checks an answer uses the non-overlapped implication;
    // a_prot_mode and a_rsvd_zero check the flops themselves. The named steps
    // come first: the requests, then the answers they must produce.

    // A floating-point instruction with no load beside it.
    sequence s_fpIssued;
        insKind == MCB_INS_FLOAT && !moveReq.wrEn;
    endsequence

    // Floating-point with the task-switched bit set.
    sequence s_fpWithTs;
        insKind == MCB_INS_FLOAT && !moveReq.wrEn
        && state_reg.ctrlWord[MCB_BIT_TASKSW];
    endsequence

    // Floating-point with the emulate bit set.
    sequence s_fpWithEm;
        insKind == MCB_INS_FLOAT && !moveReq.wrEn
        && state_reg.ctrlWord[MCB_BIT_EMULATE];
    endsequence

    // Wait with the monitor bit clear.
    sequence s_waitNoMon;
        insKind == MCB_INS_WAIT && !moveReq.wrEn
        && !state_reg.ctrlWord[MCB_BIT_MONITOR];
    endsequence

    // Wait with both the monitor and task-switched bits set.
    sequence s_waitMonTs;
        insKind == MCB_INS_WAIT && state_reg.ctrlWord[MCB_BIT_MONITOR]
        && state_reg.ctrlWord[MCB_BIT_TASKSW];
    endsequence

    // A main-word load that would turn paging on without protection.
    sequence s_badLoad;
        moveReq.wrEn && moveReq.sel == MCB_SEL_MAIN
        && moveReq.data[MCB_BIT_PAGING] && !moveReq.data[MCB_BIT_PROT];
    endsequence

    // The device-not-available answer.
    sequence s_dnaReport;
        fault.valid && fault.vector == MCB_VEC_DNA;
    endsequence

    // The general-protection answer, always with a zero code.
    sequence s_gpReport;
        fault.valid && fault.vector == MCB_VEC_GP
        && fault.errCode == 16'h0000;
    endsequence

    // Every floating-point instruction with no load beside it traps, whatever the numerics bit.
    a_fp_always_traps: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_fpIssued |=> s_dnaReport)
        else $error("Floating-point instruction did not trap 7.");

    // Task-switched set: floating-point reports vector 7.
    a_ts_fp_trap: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_fpWithTs |=> s_dnaReport)
        else $error("Task-switched floating-point missed fault 7.");

    // Emulate set: floating-point goes to the handler on vector 7.
    a_em_fp_trap: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_fpWithEm |=> s_dnaReport)
        else $error("Emulate floating-point did not trap.");

    // Monitor clear: a wait never traps.
    a_wait_no_mon: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_waitNoMon |=> !fault.valid)
        else $error("Wait trapped with monitor clear.");

    // Monitor and task-switched set: a wait traps.
    a_wait_mon_ts: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_waitMonTs |=> fault.valid)
        else $error("Wait with monitor and task-switched did not trap.");

    // Task-switched clear: a wait runs without a trap even with monitor set.
    a_wait_ts_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (insKind == MCB_INS_WAIT && !moveReq.wrEn
         && !state_reg.ctrlWord[MCB_BIT_TASKSW]) |=> !fault.valid)
        else $error("Wait trapped with task-switched clear.");

    // No instruction and no load: no fault may appear.
    a_fault_quiet: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (insKind == MCB_INS_NONE && !moveReq.wrEn) |=> !fault.valid)
        else $error("Fault reported without a cause.");

    // A task switch always leaves the task-switched bit set.
    a_ts_set: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        taskSwitch |=> state_reg.ctrlWord[MCB_BIT_TASKSW])
        else $error("Task switch did not set the task-switched bit.");

    // Write protect set: every read-only write faults.
    a_wp_fault: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (pageReq.valid && pageReq.readOnly && writeProtect)
        |=> pageFault)
        else $error("Protected read-only write did not fault.");

    // Write protect clear: levels up to the supervisor limit may write.
    a_wp_super_ok: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (pageReq.valid && pageReq.readOnly && !writeProtect
         && pageReq.cpl <= MCB_SUPER_MAX_CPL) |=> !pageFault)
        else $error("Supervisor read-only write faulted.");

    // Write protect clear: the user level still faults on read-only pages.
    a_wp_user_fault: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (pageReq.valid && pageReq.readOnly && !writeProtect
         && pageReq.cpl == 2'h3) |=> pageFault)
        else $error("User read-only write did not fault.");

    // Writable pages and idle cycles never fault.
    a_page_quiet: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !(pageReq.valid && pageReq.readOnly) |=> !pageFault)
        else $error("Page fault without a read-only write.");

    // An illegal paging load faults and leaves paging as it was.
    a_pg_no_pe: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_badLoad |=> s_gpReport ##0 $stable(pagingOn))
        else $error("Illegal paging load did not raise the fault.");

    // The refused load leaves the whole word untouched.
    a_pg_word_kept: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_badLoad ##0 !taskSwitch |=> $stable(state_reg.ctrlWord))
        else $error("Illegal paging load changed the control word.");

    // Reserved bits never hold a one.
    a_rsvd_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (state_reg.ctrlWord & ~MCB_WRITABLE_MASK) == 32'h0000_0000)
        else $error("Reserved control bit holds a one.");

    // A main-word read shows zero in every reserved bit.
    a_read_main: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (moveReq.rdEn && moveReq.sel == MCB_SEL_MAIN)
        |=> readValid && (readData & ~MCB_WRITABLE_MASK) == 32'h0000_0000)
        else $error("Main word read shows a reserved one.");

    // The reserved second word reads as a fixed zero.
    a_rsvd_word: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (moveReq.rdEn && moveReq.sel == MCB_SEL_RSVD)
        |=> readValid && readData == 32'h0000_0000)
        else $error("Reserved control word read nonzero.");

    // Writes to the reserved second word change nothing.
    a_rsvd_write: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (moveReq.wrEn && moveReq.sel == MCB_SEL_RSVD && !taskSwitch)
        |=> $stable(state_reg.ctrlWord))
        else $error("Reserved word write changed the control word.");

    // Paging never stands without protection.
    a_prot_mode: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        pagingOn |-> protMode)
        else $error("Protection mode output inconsistent.");

    // A load with protection set enters protected mode.
    a_prot_enter: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (moveReq.wrEn && moveReq.sel == MCB_SEL_MAIN
         && moveReq.data[MCB_BIT_PROT]) |=> protMode)
        else $error("Protection load did not enter protected mode.");

    // A legal load with protection clear returns to real-address mode.
    a_real_mode: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (moveReq.wrEn && moveReq.sel == MCB_SEL_MAIN
         && !moveReq.data[MCB_BIT_PROT] && !moveReq.data[MCB_BIT_PAGING])
        |=> !protMode)
        else $error("Real-mode load left protection on.");

endmodule : mcb_control
`default_nettype wire

//--- testbench/tb_cpu_machine_control_bits.sv
// Testbench for the machine control bits block: drives the move,
// instruction, task switch and page ports and checks every answer.
// Assumes the package is compiled first and a 20 MHz core clock.
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Comparison macro: counts every compare and reports a mismatch at once.
// ============================================================================
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp); \
        end \
    end
module tb_cpu_machine_control_bits
    import mcb_pkg::*;
;
    // ========================================================================
    // Signals around the block under test.
    // ========================================================================
    logic          clk_sys;      // Core clock, 50 ns period.
    logic          rst_n;        // Asynchronous reset, active low.
    mcb_move_type  moveReq;      // Register move request.
    logic          taskSwitch;   // Task switch pulse.
    mcb_ins_type   insKind;      // Instruction offered for trap checks.
    mcb_page_type  pageReq;      // Page write check.
    logic [31:0]   readData;     // Read answer.
    logic          readValid;    // Read answer strobe.
    mcb_fault_type fault;        // Fault report.
    logic          pageFault;    // Page write fault strobe.
    logic          protMode;     // Protection enable level.
    logic          pagingOn;     // Paging enable level.
    logic          writeProtect; // Write protect level.
    logic          numExcBit;    // Numerics exception level.
    logic [31:0]   word;         // Scratch control word value.
    int            fails;        // Mismatches seen.
    int            n_tests;      // Comparisons made.

    mcb_control dut (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .moveReq      (moveReq),
        .taskSwitch   (taskSwitch),
        .insKind      (insKind),
        .pageReq      (pageReq),
        .readData     (readData),
        .readValid    (readValid),
        .fault        (fault),
        .pageFault    (pageFault),
        .protMode     (protMode),
        .pagingOn     (pagingOn),
        .writeProtect (writeProtect),
        .numExcBit    (numExcBit)
    );

    // The clock toggles every half period.
    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    // ========================================================================
    // Access tasks.
    // ========================================================================
    // Presents one cycle of requests, then idles; outputs are read 1 ns
    // after the sampling edge so the registered answers have landed.
    task automatic apply(input mcb_move_type mv, input logic ts,
                         input mcb_ins_type ik, input mcb_page_type pg);
        @(posedge clk_sys);
        moveReq    <= mv;
        taskSwitch <= ts;
        insKind    <= ik;
        pageReq    <= pg;
        @(posedge clk_sys);
        moveReq    <= '0;
        taskSwitch <= 1'b0;
        insKind    <= MCB_INS_NONE;
        pageReq    <= '0;
        #1;
    endtask : apply

    // Checks the fault strobe, and its vector and code when one is due.
    task automatic chk_fault(input logic expF, input logic [7:0] vec);
        `CHK(fault.valid, expF)
        if (expF) begin
            `CHK(fault.vector, vec)
            `CHK(fault.errCode, MCB_GP_ERRCODE)
        end
    endtask : chk_fault

    // Writes a word and checks whether the load was refused.
    task automatic wr(input mcb_sel_type sel, input logic [31:0] data,
                      input logic expF, input logic [7:0] vec);
        apply('{1'b1, 1'b0, sel, data}, 1'b0, MCB_INS_NONE, '0);
        chk_fault(expF, vec);
    endtask : wr

    // Reads a word and compares it with the expected value.
    task automatic rd(input mcb_sel_type sel, input logic [31:0] exp);
        apply('{1'b0, 1'b1, sel, 32'h0000_0000}, 1'b0, MCB_INS_NONE, '0);
        `CHK(readValid, 1'b1)
        `CHK(readData, exp)
    endtask : rd

    // Offers one instruction and checks the trap decision.
    task automatic ins(input mcb_ins_type k, input logic expT);
        apply('0, 1'b0, k, '0);
        chk_fault(expT, MCB_VEC_DNA);
    endtask : ins

    // Offers one page write check and compares the fault strobe.
    task automatic pg(input logic ro, input logic [1:0] cpl, input logic e);
        apply('0, 1'b0, MCB_INS_NONE, '{1'b1, ro, cpl});
        `CHK(pageFault, e)
    endtask : pg

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // A hang is cut short here and counted as a mismatch.
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end

    // ========================================================================
    // Main sequence.
    // ========================================================================
    initial begin
        rst_n = 1'b0;
        moveReq = '0;
        taskSwitch = 1'b0;
        insKind = MCB_INS_NONE;
        pageReq = '0;
        fails = 0;
        n_tests = 0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(MCB_SEL_MAIN, MCB_RESET_VALUE);
        rd(MCB_SEL_RSVD, MCB_RSVD_VALUE);
        // All ones: reserved bits must read back as zero.
        wr(MCB_SEL_MAIN, 32'hFFFF_FFFF, 1'b0, 8'h00);
        rd(MCB_SEL_MAIN, MCB_WRITABLE_MASK);
        `CHK({protMode, pagingOn, writeProtect, numExcBit}, 4'hF)
        wr(MCB_SEL_RSVD, 32'hFFFF_FFFF, 1'b0, 8'h00);
        rd(MCB_SEL_RSVD, MCB_RSVD_VALUE);
        // Paging without protection is refused and the word kept.
        wr(MCB_SEL_MAIN, 32'h0000_0001, 1'b0, 8'h00);
        // Numerics bit clear: floating-point still traps on vector 7.
        `CHK(numExcBit, 1'b0)
        ins(MCB_INS_FLOAT, 1'b1);
        wr(MCB_SEL_MAIN, 32'h8000_0000, 1'b1, MCB_VEC_GP);
        rd(MCB_SEL_MAIN, 32'h0000_0001);
        // The load fault wins over a trap offered in the same cycle.
        apply('{1'b1, 1'b0, MCB_SEL_MAIN, 32'h8000_0000}, 1'b0,
              MCB_INS_FLOAT, '0);
        chk_fault(1'b1, MCB_VEC_GP);
        wr(MCB_SEL_MAIN, 32'h0001_0000, 1'b0, 8'h00);
        `CHK(protMode, 1'b0)
        // The alias load touches the low half only.
        wr(MCB_SEL_LOW, 32'hFFFF_FFFF, 1'b0, 8'h00);
        rd(MCB_SEL_MAIN, 32'h0001_002F);
        // Every monitor, emulate and task-switched combination.
        for (int i = 0; i < 8; i++) begin
            word = 32'h0000_0021 | {28'h0, i[2:0], 1'b0};
            wr(MCB_SEL_MAIN, word, 1'b0, 8'h00);
            ins(MCB_INS_NONE, 1'b0);
            ins(MCB_INS_FLOAT, 1'b1);
            ins(MCB_INS_WAIT, i[0] & i[2]);
        end
        // A task switch sets the bit, even against a clearing load.
        wr(MCB_SEL_MAIN, 32'h0000_0023, 1'b0, 8'h00);
        ins(MCB_INS_WAIT, 1'b0);
        apply('0, 1'b1, MCB_INS_NONE, '0);
        rd(MCB_SEL_MAIN, 32'h0000_002B);
        ins(MCB_INS_WAIT, 1'b1);
        apply('{1'b1, 1'b0, MCB_SEL_MAIN, 32'h0000_0023}, 1'b1,
              MCB_INS_NONE, '0);
        rd(MCB_SEL_MAIN, 32'h0000_002B);
        // Read-only page writes with and without write protect.
        for (int wp = 0; wp < 2; wp++) begin
            word = (wp == 1) ? 32'h0001_0025 : 32'h0000_0025;
            wr(MCB_SEL_MAIN, word, 1'b0, 8'h00);
            for (int c = 0; c < 4; c++) begin
                pg(1'b1, c[1:0], (wp == 1) || (c == 3));
                pg(1'b0, c[1:0], 1'b0);
            end
        end
        // A second reset in mid-run clears the word again.
        @(posedge clk_sys);
        rst_n <= 1'b0;
        #1;
        `CHK({protMode, writeProtect, numExcBit, fault.valid}, 4'h0)
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(MCB_SEL_MAIN, MCB_RESET_VALUE);
        report_and_stop();
    end

endmodule : tb_cpu_machine_control_bits
`undef CHK
`default_nettype wire
